// *** shared/line_cfg_pkg.sv ***
// Constants for the line interface configuration register group
package line_cfg_pkg;

    // =========================================================
    // Bus geometry and responses
    localparam int         ADDR_W      = 4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // =========================================================
    // Register word indices (byte address = index * 4)
    localparam logic [1:0] IDX_HOOK = 2'h0;
    localparam logic [1:0] IDX_LOOP = 2'h1;
    localparam logic [1:0] IDX_REV  = 2'h2;

    // =========================================================
    // Reset values and write masks
    localparam logic [7:0] HOOK_RESET  = 8'h00;
    localparam logic [7:0] LOOP_RESET  = 8'hF0;
    localparam logic [1:0] REV_DC_RESET = 2'h0;
    localparam logic [7:0] HOOK_WMASK  = 8'h3F;

    // =========================================================
    // Field positions
    localparam int HOOK_SPEED_LSB = 4;
    localparam int HOOK_CAP_BIT   = 3;
    localparam int HOOK_RZ_BIT    = 2;
    localparam int HOOK_RT_BIT    = 0;
    localparam int LOOP_MIN_LSB   = 6;
    localparam int LOOP_VOLT_LSB  = 4;
    localparam int LOOP_AC_LSB    = 0;
    localparam int REV_LSB        = 4;
    localparam int REV_DC_BIT     = 1;

    // =========================================================
    // Decoded analog settings
    localparam logic [6:0] CAP_LIMIT_MA = 7'h3C;
    localparam logic [4:0] MIN_MA_10    = 5'h0A;
    localparam logic [4:0] MIN_MA_12    = 5'h0C;
    localparam logic [4:0] MIN_MA_14    = 5'h0E;
    localparam logic [8:0] VOLT_CV_310  = 9'h136;
    localparam logic [8:0] VOLT_CV_320  = 9'h140;
    localparam logic [8:0] VOLT_CV_335  = 9'h14F;
    localparam logic [3:0] AC_REAL600   = 4'h0;
    localparam logic [3:0] AC_GLOBAL    = 4'h3;
    localparam logic [3:0] AC_NZ        = 4'h4;
    localparam logic [3:0] AC_GLOBAL2   = 4'hF;
    localparam logic [3:0] NET_REAL600  = 4'h1;
    localparam logic [3:0] NET_GLOBAL   = 4'h2;
    localparam logic [3:0] NET_NZ       = 4'h4;
    localparam logic [3:0] NET_GLOBAL2  = 4'h8;

    // =========================================================
    // Bus channel states
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP    = 2'b10
    } wr_state_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_type;

endpackage

// *** hdl/revision_sync.sv ***
// Two-stage synchroniser for the line-side revision pins
module revision_sync
    import line_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Asynchronous pins in, synchronised value out
    input  wire logic [3:0] din,
    output logic      [3:0] dout
);

    // =========================================================
    // Stages
    logic [3:0] stage1_q;   // Only read by the second stage
    logic [3:0] stage1_d;
    logic [3:0] stage2_q;   // Safe to use
    logic [3:0] stage2_d;

    // Next values
    always_comb
    begin
        stage1_d = din;
        stage2_d = stage1_q;
    end

    // Register both stages
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1_q <= 4'h0;
            stage2_q <= 4'h0;
        end
        else
        begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign dout = stage2_q;

endmodule

// *** hdl/line_interface_config_regs.sv ***
// AXI4-Lite register group for line interface configuration
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
module line_interface_config_regs
    import line_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // AXI4-Lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // AXI4-Lite read data
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Line-side revision pins
    input  wire logic [3:0]        line_side_revision,
    // Hook and ringer settings
    output logic [1:0]             onhook_speed_sel,
    output logic                   onhook_start,
    output logic                   loop_current_cap_en,
    output logic [6:0]             loop_current_cap_ma,
    output logic                   ringer_impedance_sel,
    output logic                   ring_threshold_sel,
    // Loop and termination settings
    output logic [1:0]             min_loop_current_sel,
    output logic [4:0]             min_loop_current_ma,
    output logic [1:0]             line_voltage_adjust,
    output logic [8:0]             line_voltage_set_pin,
    output logic [3:0]             ac_termination_sel,
    output logic [3:0]             ac_term_network,
    output logic                   dc_termination_sel
);

    // =========================================================
    // Decode helpers

    // Word index of a byte address; low two bits ignored
    function automatic logic [1:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = a[3:2];
    endfunction

    // Minimum loop current in mA; unused code falls back to 10
    function automatic logic [4:0] min_ma(input logic [1:0] s);
        if (s == 2'h1)
            min_ma = MIN_MA_12;
        else if (s == 2'h2)
            min_ma = MIN_MA_14;
        else
            min_ma = MIN_MA_10;
    endfunction

    // Voltage pin target in hundredths of a volt
    function automatic logic [8:0] volt_cv(input logic [1:0] s);
        if (s == 2'h1)
            volt_cv = VOLT_CV_320;
        else if (s == 2'h2)
            volt_cv = VOLT_CV_335;
        else
            volt_cv = VOLT_CV_310;
    endfunction

    // One-hot network select; unlisted codes select nothing
    function automatic logic [3:0] ac_net(input logic [3:0] s);
        if (s == AC_REAL600)
            ac_net = NET_REAL600;
        else if (s == AC_GLOBAL)
            ac_net = NET_GLOBAL;
        else if (s == AC_NZ)
            ac_net = NET_NZ;
        else if (s == AC_GLOBAL2)
            ac_net = NET_GLOBAL2;
        else
            ac_net = 4'h0;
    endfunction

    // =========================================================
    // Write channel and configuration state
    wr_state_type     wr_state_q, wr_state_d;
    logic             aw_have_q, aw_have_d;     // Address held
    logic             w_have_q, w_have_d;       // Data held
    logic [1:0]       waddr_q, waddr_d;         // Held word index
    logic [7:0]       wbyte_q, wbyte_d;         // Held low byte
    logic             wlane_q, wlane_d;         // Low lane enabled
    logic             awready_q, awready_d;
    logic             wready_q, wready_d;
    logic             bvalid_q, bvalid_d;
    logic [1:0]       bresp_q, bresp_d;
    logic [7:0]       hook_q, hook_d;           // hook_ringer_control
    logic [7:0]       loop_q, loop_d;           // loop_termination_control
    logic [1:0]       rev_dc_q, rev_dc_d;       // Writable bits 1:0
    logic             onhook_q, onhook_d;       // Start-of-hook pulse
    logic [4:0]       min_ma_q, min_ma_d;
    logic [8:0]       volt_q, volt_d;
    logic [3:0]       net_q, net_d;
    logic [6:0]       cap_ma_q, cap_ma_d;       // Cap level in mA
    logic             wr_fire;                  // Both halves held

    assign wr_fire = (wr_state_q == WR_COLLECT) && aw_have_q && w_have_q;

    // Next values of the write side
    always_comb
    begin
        wr_state_d = wr_state_q;
        aw_have_d  = aw_have_q;
        w_have_d   = w_have_q;
        waddr_d    = waddr_q;
        wbyte_d    = wbyte_q;
        wlane_d    = wlane_q;
        bvalid_d   = bvalid_q;
        bresp_d    = bresp_q;
        hook_d     = hook_q;
        loop_d     = loop_q;
        rev_dc_d   = rev_dc_q;
        onhook_d   = 1'b0;
        case (wr_state_q)
            WR_COLLECT:
            begin
                // Address and data may arrive in either order
                if (awvalid && awready_q)
                begin
                    aw_have_d = 1'b1;
                    waddr_d   = word_idx(awaddr);
                end
                if (wvalid && wready_q)
                begin
                    w_have_d = 1'b1;
                    wbyte_d  = wdata[7:0];
                    wlane_d  = wstrb[0];
                end
                if (wr_fire)
                begin
                    aw_have_d  = 1'b0;
                    w_have_d   = 1'b0;
                    bvalid_d   = 1'b1;
                    bresp_d    = RESP_OKAY;
                    wr_state_d = WR_RESP;
                    if (waddr_q == IDX_HOOK)
                    begin
                        if (wlane_q)
                        begin
                            // Reserved bit 1 kept as written
                            hook_d   = wbyte_q & HOOK_WMASK;
                            onhook_d = 1'b1;
                        end
                    end
                    else if (waddr_q == IDX_LOOP)
                    begin
                        if (wlane_q)
                            loop_d = wbyte_q;
                    end
                    else if (waddr_q == IDX_REV)
                    begin
                        // Revision nibble is read-only, bits 1:0 stored
                        if (wlane_q)
                            rev_dc_d = wbyte_q[1:0];
                    end
                    else
                    begin
                        // Unmapped word
                        bresp_d = RESP_SLVERR;
                    end
                end
            end
            WR_RESP:
            begin
                if (bready)
                begin
                    bvalid_d   = 1'b0;
                    wr_state_d = WR_COLLECT;
                end
            end
            default:
            begin
                wr_state_d = WR_COLLECT;
            end
        endcase
        // Ready only while that half is still wanted
        awready_d = (wr_state_d == WR_COLLECT) && !aw_have_d;
        wready_d  = (wr_state_d == WR_COLLECT) && !w_have_d;
        // Decoded outputs follow the stored fields on the same edge
        min_ma_d = min_ma(loop_d[LOOP_MIN_LSB +: 2]);
        volt_d   = volt_cv(loop_d[LOOP_VOLT_LSB +: 2]);
        net_d    = ac_net(loop_d[LOOP_AC_LSB +: 4]);
        cap_ma_d = hook_d[HOOK_CAP_BIT] ? CAP_LIMIT_MA : 7'h00;
    end

    // Register the write side
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_q <= WR_COLLECT;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            waddr_q    <= 2'h0;
            wbyte_q    <= 8'h00;
            wlane_q    <= 1'b0;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RESP_OKAY;
            hook_q     <= HOOK_RESET;
            loop_q     <= LOOP_RESET;
            rev_dc_q   <= REV_DC_RESET;
            onhook_q   <= 1'b0;
            min_ma_q   <= MIN_MA_10;
            volt_q     <= VOLT_CV_310;
            net_q      <= NET_REAL600;
            cap_ma_q   <= 7'h00;
        end
        else
        begin
            wr_state_q <= wr_state_d;
            aw_have_q  <= aw_have_d;
            w_have_q   <= w_have_d;
            waddr_q    <= waddr_d;
            wbyte_q    <= wbyte_d;
            wlane_q    <= wlane_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            hook_q     <= hook_d;
            loop_q     <= loop_d;
            rev_dc_q   <= rev_dc_d;
            onhook_q   <= onhook_d;
            min_ma_q   <= min_ma_d;
            volt_q     <= volt_d;
            net_q      <= net_d;
            cap_ma_q   <= cap_ma_d;
        end
    end

    // =========================================================
    // Revision pins come from the isolated side
    logic [3:0] rev_sync;

    revision_sync u_rev_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (line_side_revision),
        .dout    (rev_sync)
    );

    // =========================================================
    // Read channel
    rd_state_type     rd_state_q, rd_state_d;
    logic             arready_q, arready_d;
    logic             rvalid_q, rvalid_d;
    logic [1:0]       rresp_q, rresp_d;
    logic [7:0]       rbyte_q, rbyte_d;        // Upper bits read zero
    logic [1:0]       ridx_q, ridx_d;          // Word being answered

    // Next values of the read side
    always_comb
    begin
        rd_state_d = rd_state_q;
        rvalid_d   = rvalid_q;
        rresp_d    = rresp_q;
        rbyte_d    = rbyte_q;
        ridx_d     = ridx_q;
        case (rd_state_q)
            RD_IDLE:
            begin
                if (arvalid && arready_q)
                begin
                    ridx_d     = word_idx(araddr);
                    rvalid_d   = 1'b1;
                    rresp_d    = RESP_OKAY;
                    rd_state_d = RD_RESP;
                    if (word_idx(araddr) == IDX_HOOK)
                        rbyte_d = hook_q & HOOK_WMASK;
                    else if (word_idx(araddr) == IDX_LOOP)
                        rbyte_d = loop_q;
                    else if (word_idx(araddr) == IDX_REV)
                        // Indeterminate pair reads as zero
                        rbyte_d = {rev_sync, 2'h0, rev_dc_q};
                    else
                    begin
                        rbyte_d = 8'h00;
                        rresp_d = RESP_SLVERR;
                    end
                end
            end
            RD_RESP:
            begin
                if (rready)
                begin
                    rvalid_d   = 1'b0;
                    rd_state_d = RD_IDLE;
                end
            end
            default:
            begin
                rd_state_d = RD_IDLE;
            end
        endcase
        // One read in flight; no new address until answered
        arready_d = (rd_state_d == RD_IDLE);
    end

    // Register the read side
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state_q <= RD_IDLE;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            rresp_q    <= RESP_OKAY;
            rbyte_q    <= 8'h00;
            ridx_q     <= 2'h0;
        end
        else
        begin
            rd_state_q <= rd_state_d;
            arready_q  <= arready_d;
            rvalid_q   <= rvalid_d;
            rresp_q    <= rresp_d;
            rbyte_q    <= rbyte_d;
            ridx_q     <= ridx_d;
        end
    end

    // =========================================================
    // Outputs, all straight from flip-flops
    assign awready              = awready_q;
    assign wready               = wready_q;
    assign bvalid               = bvalid_q;
    assign bresp                = bresp_q;
    assign arready              = arready_q;
    assign rvalid               = rvalid_q;
    assign rresp                = rresp_q;
    assign rdata                = {24'h000000, rbyte_q};
    assign onhook_speed_sel     = hook_q[HOOK_SPEED_LSB +: 2];
    assign onhook_start         = onhook_q;
    assign loop_current_cap_en  = hook_q[HOOK_CAP_BIT];
    assign ringer_impedance_sel = hook_q[HOOK_RZ_BIT];
    assign ring_threshold_sel   = hook_q[HOOK_RT_BIT];
    assign min_loop_current_sel = loop_q[LOOP_MIN_LSB +: 2];
    assign min_loop_current_ma  = min_ma_q;
    assign line_voltage_adjust  = loop_q[LOOP_VOLT_LSB +: 2];
    assign line_voltage_set_pin = volt_q;
    assign ac_termination_sel   = loop_q[LOOP_AC_LSB +: 4];
    assign ac_term_network      = net_q;
    assign dc_termination_sel   = rev_dc_q[REV_DC_BIT];
    // Cap level is 60 mA while the cap is enabled, else 0; registered so the pin never glitches
    assign loop_current_cap_ma  = cap_ma_q;

    // =========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence hook_write_s;
        wr_fire && (waddr_q == IDX_HOOK) && wlane_q;
    endsequence

    sequence rev_read_s;
        arvalid && arready_q && (word_idx(araddr) == IDX_REV);
    endsequence

    onhook_pulse_a: assert property (
        hook_write_s |=> onhook_start ##1 !onhook_start)
        else $error("on-hook start pulse missing or too long");

    cap_enable_a: assert property (
        hook_write_s ##0 wbyte_q[HOOK_CAP_BIT]
        |=> loop_current_cap_en && (loop_current_cap_ma == 7'h3C))
        else $error("loop current cap not applied");

    ringer_sel_a: assert property (
        hook_write_s |=> ringer_impedance_sel == $past(wbyte_q[2]))
        else $error("ringer impedance select wrong");

    ring_thresh_a: assert property (
        hook_write_s |=> ring_threshold_sel == $past(wbyte_q[0]))
        else $error("ring threshold select wrong");

    min_current_a: assert property (
        (min_loop_current_sel == 2'h1) |-> min_loop_current_ma == 5'h0C)
        else $error("minimum loop current decode wrong");

    line_volt_a: assert property (
        (line_voltage_adjust == 2'h2) |-> line_voltage_set_pin == 9'h14F)
        else $error("line voltage decode wrong");

    ac_network_a: assert property (
        (ac_termination_sel == 4'h4) |-> ac_term_network == 4'h4)
        else $error("ac termination decode wrong");

    rev_read_a: assert property (
        rev_read_s |=> rvalid && (rdata[7:4] == $past(rev_sync))
        && (rdata[3:2] == 2'h0))
        else $error("revision readback wrong");

    dc_term_a: assert property (
        wr_fire && (waddr_q == IDX_REV) && wlane_q
        |=> dc_termination_sel == $past(wbyte_q[1]))
        else $error("dc termination select wrong");

    reset_values_a: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> (hook_q == 8'h00) && (loop_q == 8'hF0))
        else $error("reset defaults not loaded");

    bresp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the line interface configuration registers
module testbench
    import line_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Bench signals
    logic              aclk, aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb, line_side_revision, ac_termination_sel;
    logic [3:0]        ac_term_network;
    logic [1:0]        bresp, rresp, onhook_speed_sel;
    logic [1:0]        min_loop_current_sel, line_voltage_adjust;
    logic              bvalid, bready, arvalid, arready, rvalid, rready;
    logic              onhook_start, loop_current_cap_en;
    logic              ringer_impedance_sel, ring_threshold_sel;
    logic              dc_termination_sel;
    logic [6:0]        loop_current_cap_ma;
    logic [4:0]        min_loop_current_ma;
    logic [8:0]        line_voltage_set_pin;
    int                fail_count, check_count, cycles;
    logic [1:0]        r;
    logic [31:0]       q;
    logic [7:0]        d;
    logic              st;

    line_interface_config_regs u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .line_side_revision(line_side_revision),
        .onhook_speed_sel(onhook_speed_sel), .onhook_start(onhook_start),
        .loop_current_cap_en(loop_current_cap_en),
        .loop_current_cap_ma(loop_current_cap_ma),
        .ringer_impedance_sel(ringer_impedance_sel),
        .ring_threshold_sel(ring_threshold_sel),
        .min_loop_current_sel(min_loop_current_sel),
        .min_loop_current_ma(min_loop_current_ma),
        .line_voltage_adjust(line_voltage_adjust),
        .line_voltage_set_pin(line_voltage_set_pin),
        .ac_termination_sel(ac_termination_sel),
        .ac_term_network(ac_term_network),
        .dc_termination_sel(dc_termination_sel)
    );

    // ==========================================================
    // Clock and hang guard; the run needs well under 2000 cycles
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    // ==========================================================
    // Expected decodes
    function automatic logic [4:0] exp_ma(input logic [1:0] c);
        return (c == 2'h1) ? MIN_MA_12 : (c == 2'h2) ? MIN_MA_14 : MIN_MA_10;
    endfunction
    function automatic logic [8:0] exp_cv(input logic [1:0] c);
        return (c == 2'h1) ? VOLT_CV_320 :
               (c == 2'h2) ? VOLT_CV_335 : VOLT_CV_310;
    endfunction
    function automatic logic [3:0] exp_net(input logic [3:0] c);
        return (c == 4'h0) ? 4'h1 : (c == 4'h3) ? 4'h2 :
               (c == 4'h4) ? 4'h4 : (c == 4'hF) ? 4'h8 : 4'h0;
    endfunction

    // ==========================================================
    // Compare, verdict and bus tasks
    task automatic check(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Handshakes are judged on values settled before the sampling edge
    task automatic wr(input logic [3:0] a, input logic [7:0] v,
                      input logic [3:0] s);
        logic aw_t, w_t, b_t, b_seen;
        b_t = 1'b0;
        st = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'hA5C3E1, v};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'($urandom);  // Late bready now and then
        while (!b_t)
        begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            b_seen = bvalid;
            r = bresp;
            if (onhook_start === 1'b1)
                st = 1'b1;
            @(posedge aclk);
            if (aw_t)
                awvalid <= 1'b0;
            if (w_t)
                wvalid <= 1'b0;
            if (b_t)
                bready <= 1'b0;
            else if (b_seen)
                bready <= 1'b1;
        end
    endtask
    task automatic rd(input logic [3:0] a);
        logic ar_t, r_t;
        r_t = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!r_t)
        begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            r_t = rvalid && rready;
            q = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_t)
                arvalid <= 1'b0;
            if (r_t)
                rready <= 1'b0;
        end
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'hC853));
        {aresetn, awaddr, araddr, awvalid, wvalid, bready} = '0;
        {wdata, wstrb, arvalid, rready, cycles} = '0;
        {fail_count, check_count} = '0;
        line_side_revision = 4'h9;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        // Defaults after reset
        rd(4'h0);
        check("hook reset", q, 32'h0);
        rd(4'h4);
        check("loop reset", q, 32'hF0);
        check("min ma", min_loop_current_ma, MIN_MA_10);
        check("volt", line_voltage_set_pin, VOLT_CV_310);
        check("net", ac_term_network, 4'h1);
        rd(4'h8);
        check("rev reset", q & 32'hF3, 32'h90);
        // Random hook settings, start pulse on each write
        repeat (8)
        begin
            rd(4'h0);
            d = 8'($urandom);
            d[1] = q[1];
            wr(4'h0, d, 4'h1);
            check("hook bresp", r, RESP_OKAY);
            check("hook start", st, 1'b1);
            check("speed", onhook_speed_sel, d[5:4]);
            check("cap en", loop_current_cap_en, d[3]);
            check("cap ma", loop_current_cap_ma,
                  d[3] ? CAP_LIMIT_MA : 7'h00);
            check("rz", ringer_impedance_sel, d[2]);
            check("rt", ring_threshold_sel, d[0]);
            rd(4'h0);
            check("hook rd", q, {24'h0, d & 8'h3F});
        end
        // Strobe low leaves the register alone
        wr(4'h0, ~d, 4'hE);
        check("no strobe start", st, 1'b0);
        rd(4'h0);
        check("no strobe rd", q, {24'h0, d & 8'h3F});
        // Every termination code once, cycling through all current and voltage codes
        for (int i = 0; i < 16; i++)
        begin
            d = {i[1:0], i[3:2], i[3:0]};
            wr(4'h4, d, 4'h1);
            check("min ma", min_loop_current_ma, exp_ma(d[7:6]));
            check("volt", line_voltage_set_pin, exp_cv(d[5:4]));
            check("net", ac_term_network, exp_net(d[3:0]));
            check("act", ac_termination_sel, d[3:0]);
            check("mini", min_loop_current_sel, d[7:6]);
            check("dcv", line_voltage_adjust, d[5:4]);
            rd(4'h4);
            check("loop rresp", r, RESP_OKAY);
            check("loop rd", q, {24'h0, d});
        end
        // Revision follows the pins, dc select stored
        repeat (4)
        begin
            rd(4'h8);
            d = 8'($urandom);
            d[0] = q[0];
            line_side_revision <= 4'($urandom);
            wr(4'h8, d, 4'h1);
            check("dc sel", dc_termination_sel, d[1]);
            rd(4'h8);
            check("rev rd", q & 32'hF3,
                  {24'h0, line_side_revision, 2'h0, d[1:0]});
        end
        // Unmapped word is refused
        wr(4'hC, 8'hFF, 4'hF);
        check("unmapped b", r, RESP_SLVERR);
        rd(4'hC);
        check("unmapped r", r, RESP_SLVERR);
        check("unmapped d", q, 32'h0);
        give_verdict();
    end
endmodule
